/* hdl/cfs_map.svh */
// register addresses, field positions and reset values of the configuration block
`ifndef CFS_MAP_SVH
`define CFS_MAP_SVH
`define CFS_CFG1_ADDR 16'hfd00
`define CFS_CFG2_ADDR 16'hfd01
`define CFS_WDT_BIT 7
`define CFS_RST_PIN_DIS_BIT 6
`define CFS_PRL_BIT 5
`define CFS_BO_SEL_BIT 4
`define CFS_CLK_RATE_BIT 3
`define CFS_OSC_MSB 2
`define CFS_OSC_LSB 0
`define CFS_ERASED 8'hff
`define CFS_SB_ERASED 2'h3
`endif

/* hdl/cfs_pkg.sv */
// types of the configuration and security block
package cfs_pkg;
  typedef enum logic [2:0] {
    CFS_OSC_HF_XTAL = 3'h0,
    CFS_OSC_MF_XTAL = 3'h1,
    CFS_OSC_LF_XTAL = 3'h2,
    CFS_OSC_INT_RC = 3'h3,
    CFS_OSC_EXT_CLK = 3'h7
  } cfs_osc_e;
  typedef enum logic [1:0] {
    CFS_BO_3V8 = 2'h0,
    CFS_BO_2V5 = 2'h1
  } cfs_bo_e;
endpackage

/* hdl/cfs_config_fuse_security.sv */
// configuration byte loader and security gate
//
// Behaviour
// - configuration recaptured from the fuses every cycle out of reset, erased 8'hff in reset; firmware has no write path to it.
// - firmware reads configuration bytes at fixed external-data addresses.
// - reset-pin-disable set frees shared reset pin as input-only port bit.
// - port reset level bit selects port output level after reset; during reset the erased byte holds it high.
// - brownout select 1 gives 2.5V threshold, 0 gives 3.8V.
// - security bits read 1 unprogrammed; both 1 means no protection.
// - unprotected device returns program memory data to verify requests.
// - first bit programmed blocks memory writes, second bit still programmable.
// - both bits programmed blocks verify and programming.
`timescale 1ns/1ns
`include "cfs_map.svh"

module cfs_config_fuse_security #(
  parameter int ADDR_W = 16,
  parameter int PORT_W = 8
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // nonvolatile contents
  input wire logic [7:0] cfg1_fuse_in,
  input wire logic [7:0] cfg2_fuse_in,
  input wire logic [1:0] lock_fuse_in,
  // firmware external-data read
  input wire logic fw_rd_in,
  input wire logic [ADDR_W-1:0] fw_addr_in,
  output logic [7:0] fw_rdata_out,
  output logic fw_hit_out,
  // programmer requests
  input wire logic prog_wr_in,
  input wire logic prog_lock_wr_in,
  input wire logic [1:0] prog_lock_data_in,
  input wire logic prog_verify_in,
  input wire logic [7:0] mem_rdata_in,
  output logic mem_wr_en_out,
  output logic lock_wr_en_out,
  output logic [7:0] verify_data_out,
  output logic prog_refused_out,
  // shared reset pin
  input wire logic shared_reset_port_pin_in,
  output logic ext_reset_out,
  output logic port_pin_in_out,
  // applied settings
  output logic port_reset_level_out,
  output logic [PORT_W-1:0] port_reset_value_out,
  output cfs_pkg::cfs_bo_e brownout_sel_out,
  output cfs_pkg::cfs_osc_e osc_sel_out,
  output logic osc_reserved_out,
  output logic watchdog_enable_out,
  output logic clock_rate_out
);
  import cfs_pkg::*;

  logic [7:0] system_config_byte1;
  logic [7:0] system_config_byte2;
  logic [1:0] lock_bits;
  logic program_lock_bit;
  logic verify_lock_bit;
  logic lock_open;
  logic lock_write_only;
  logic lock_unsupported;
  logic lock_closed;
  logic [1:0] next_lock_bits;
  logic cfg1_sel;
  logic cfg2_sel;
  logic verify_allowed;
  logic [2:0] osc_code;
  logic next_refused;

  // ---------------------------------
  // configuration capture
  // ---------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      system_config_byte1 <= `CFS_ERASED;
      system_config_byte2 <= `CFS_ERASED;
    end else begin
      system_config_byte1 <= cfg1_fuse_in;
      system_config_byte2 <= cfg2_fuse_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      lock_bits <= `CFS_SB_ERASED;
    end else begin
      lock_bits <= lock_fuse_in;
    end
  end

  assign program_lock_bit = lock_bits[0];
  assign verify_lock_bit = lock_bits[1];

  // ---------------------------------
  // security state decode
  // ---------------------------------
  always_comb begin
    lock_open = 1'b0;
    lock_write_only = 1'b0;
    lock_unsupported = 1'b0;
    lock_closed = 1'b0;
    case ({verify_lock_bit, program_lock_bit})
      2'h3: begin
        lock_open = 1'b1;
      end
      2'h2: begin
        lock_write_only = 1'b1;
      end
      2'h1: begin
        lock_unsupported = 1'b1;
      end
      default: begin
        lock_closed = 1'b1;
      end
    endcase
  end

  // ---------------------------------
  // firmware read port
  // ---------------------------------
  assign cfg1_sel = fw_rd_in && (fw_addr_in == ADDR_W'(`CFS_CFG1_ADDR));
  assign cfg2_sel = fw_rd_in && (fw_addr_in == ADDR_W'(`CFS_CFG2_ADDR));

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      fw_rdata_out <= 8'h00;
    end else if (cfg1_sel) begin
      fw_rdata_out <= system_config_byte1;
    end else if (cfg2_sel) begin
      fw_rdata_out <= system_config_byte2;
    end else begin
      fw_rdata_out <= 8'h00;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      fw_hit_out <= 1'b0;
    end else begin
      fw_hit_out <= cfg1_sel || cfg2_sel;
    end
  end

  // ---------------------------------
  // security gate
  // ---------------------------------
  // lock writes only clear bits; the only-second-bit state is refused
  assign next_lock_bits = lock_bits & prog_lock_data_in;
  assign verify_allowed = lock_open || lock_write_only || lock_unsupported;

  always_comb begin
    mem_wr_en_out = prog_wr_in && lock_open;
    lock_wr_en_out = prog_lock_wr_in && !lock_closed && (next_lock_bits != 2'h1);
    next_refused = (prog_wr_in && !mem_wr_en_out) ||
      (prog_verify_in && !verify_allowed) ||
      (prog_lock_wr_in && !lock_wr_en_out);
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      prog_refused_out <= 1'b0;
    end else begin
      prog_refused_out <= next_refused;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      verify_data_out <= 8'h00;
    end else if (prog_verify_in && verify_allowed) begin
      verify_data_out <= mem_rdata_in;
    end else begin
      verify_data_out <= 8'h00;
    end
  end

  // ---------------------------------
  // shared reset pin
  // ---------------------------------
  assign ext_reset_out = !system_config_byte1[`CFS_RST_PIN_DIS_BIT] &&
    !shared_reset_port_pin_in;
  assign port_pin_in_out = system_config_byte1[`CFS_RST_PIN_DIS_BIT] &&
    shared_reset_port_pin_in;

  // ---------------------------------
  // port reset level
  // ---------------------------------
  assign port_reset_level_out = system_config_byte1[`CFS_PRL_BIT];
  for (genvar b = 0; b < PORT_W; b++) begin : g_port_rst
    assign port_reset_value_out[b] = system_config_byte1[`CFS_PRL_BIT];
  end

  // ---------------------------------
  // applied settings
  // ---------------------------------
  assign brownout_sel_out = system_config_byte1[`CFS_BO_SEL_BIT] ?
    CFS_BO_2V5 : CFS_BO_3V8;
  assign watchdog_enable_out = system_config_byte1[`CFS_WDT_BIT];
  assign clock_rate_out = system_config_byte1[`CFS_CLK_RATE_BIT];

  // ---------------------------------
  // oscillator select
  // ---------------------------------
  assign osc_code = system_config_byte1[`CFS_OSC_MSB:`CFS_OSC_LSB];

  always_comb begin
    osc_reserved_out = 1'b0;
    case (osc_code)
      3'h7: osc_sel_out = CFS_OSC_EXT_CLK;
      3'h3: osc_sel_out = CFS_OSC_INT_RC;
      3'h2: osc_sel_out = CFS_OSC_LF_XTAL;
      3'h1: osc_sel_out = CFS_OSC_MF_XTAL;
      3'h0: osc_sel_out = CFS_OSC_HF_XTAL;
      default: begin
        osc_sel_out = CFS_OSC_EXT_CLK;
        osc_reserved_out = 1'b1;
      end
    endcase
  end
endmodule

/* test/cfs_monitor.sv */
// checker for the configuration and security block
`timescale 1ns/1ns
`include "cfs_map.svh"
module cfs_monitor #(parameter int ADDR_W = 16, parameter int PORT_W = 8) (
  input wire logic clock_in, rst_n_in, fw_rd_in, prog_wr_in, prog_lock_wr_in, prog_verify_in,
  input wire logic shared_reset_port_pin_in, fw_hit_out, mem_wr_en_out, lock_wr_en_out,
  input wire logic prog_refused_out, ext_reset_out, port_pin_in_out,
  input wire logic [7:0] cfg1_fuse_in, mem_rdata_in, fw_rdata_out, verify_data_out,
  input wire logic [1:0] lock_fuse_in, prog_lock_data_in,
  input wire logic [ADDR_W-1:0] fw_addr_in,
  input wire logic [PORT_W-1:0] port_reset_value_out,
  input wire cfs_pkg::cfs_bo_e brownout_sel_out
);
  // one cycle after release the capture is still the erased default
  logic live;
  always_ff @(posedge clock_in) live <= rst_n_in;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in || !live);
  sequence s_verify;
    prog_verify_in && $past(lock_fuse_in) != 2'h0;
  endsequence
  a_write_gate: assert property (
    prog_wr_in |-> mem_wr_en_out == ($past(lock_fuse_in) == 2'h3)) else $error("write gate");
  a_lock_gate: assert property (
    prog_lock_wr_in |-> lock_wr_en_out == ($past(lock_fuse_in) != 2'h0 &&
      ($past(lock_fuse_in) & prog_lock_data_in) != 2'h1)) else $error("lock gate");
  a_verify_data: assert property (
    s_verify |=> verify_data_out == $past(mem_rdata_in)) else $error("verify data");
  a_verify_block: assert property (
    !$past(lock_fuse_in) && prog_verify_in |=> !verify_data_out && prog_refused_out)
    else $error("verify not blocked");
  a_read_hit: assert property (
    fw_rd_in && fw_addr_in == `CFS_CFG1_ADDR |=> fw_hit_out && fw_rdata_out == $past(cfg1_fuse_in, 2))
    else $error("config read");
  a_pin_free: assert property (
    $past(cfg1_fuse_in[6]) |-> !ext_reset_out && port_pin_in_out == shared_reset_port_pin_in)
    else $error("reset pin");
  a_port_level: assert property (
    port_reset_value_out == {PORT_W{$past(cfg1_fuse_in[5])}}) else $error("port level");
  a_brownout_sel: assert property (
    brownout_sel_out == {1'b0, $past(cfg1_fuse_in[4])}) else $error("brownout select");
endmodule
bind cfs_config_fuse_security cfs_monitor #(.ADDR_W(ADDR_W), .PORT_W(PORT_W)) mon_u (.*);

/* test/cfs_mem_model.sv */
// program memory model on the programmer side
`timescale 1ns/1ns
module cfs_mem_model (
  input wire logic clock_in,
  output logic [7:0] mem_rdata_out
);
  // data moves every cycle so a stale verify shows
  initial mem_rdata_out = 8'h5a;
  always @(posedge clock_in) mem_rdata_out <= mem_rdata_out + 8'h3b;
endmodule

/* test/config_fuse_security_bench.sv */
// bench for the configuration and security block
`timescale 1ns/1ns
`include "cfs_map.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module config_fuse_security_bench;
  logic clock_in = 0, rst_n_in = 0, fw_rd_in = 0, prog_wr_in = 0, prog_lock_wr_in = 0;
  logic prog_verify_in = 0, shared_reset_port_pin_in = 1, fw_hit_out, mem_wr_en_out;
  logic lock_wr_en_out, prog_refused_out, ext_reset_out, port_pin_in_out, port_reset_level_out;
  logic osc_reserved_out, watchdog_enable_out, clock_rate_out;
  logic [7:0] cfg1_fuse_in = 8'hff, cfg2_fuse_in = 8'h96, mem_rdata_in, fw_rdata_out;
  logic [7:0] verify_data_out, port_reset_value_out;
  logic [15:0] fw_addr_in = 16'h0;
  logic [1:0] lock_fuse_in = 2'h3, prog_lock_data_in = 2'h2;
  cfs_pkg::cfs_bo_e brownout_sel_out;
  cfs_pkg::cfs_osc_e osc_sel_out;
  int fail_count = 0, checks_done = 0;
  always #2 clock_in = ~clock_in;
  cfs_mem_model mem_u (.clock_in(clock_in), .mem_rdata_out(mem_rdata_in));
  cfs_config_fuse_security dut_u (.*);
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e, logic h);
    @(posedge clock_in);
    fw_rd_in <= 1'b1;
    fw_addr_in <= a;
    @(posedge clock_in);
    fw_rd_in <= 1'b0;
    #1;
    `CHK("hit", h, fw_hit_out)
    `CHK("rdata", e, fw_rdata_out)
  endtask
  task automatic sec(logic [1:0] l);
    logic [7:0] m;
    @(posedge clock_in);
    lock_fuse_in <= l;
    repeat (2) @(posedge clock_in);
    {prog_wr_in, prog_lock_wr_in} <= 2'h3;
    #1;
    `CHK("wr", l == 2'h3, mem_wr_en_out)
    `CHK("lock_wr", l != 2'h0, lock_wr_en_out)
    @(posedge clock_in);
    {prog_wr_in, prog_lock_wr_in, prog_verify_in} <= 3'h1;
    #1;
    `CHK("refused", l != 2'h3, prog_refused_out)
    m = mem_rdata_in;
    @(posedge clock_in);
    prog_verify_in <= 1'b0;
    #1;
    `CHK("verify", l != 2'h0 ? m : 8'h00, verify_data_out)
    `CHK("verify_refused", l == 2'h0, prog_refused_out)
  endtask
  initial begin
    repeat (11) @(posedge clock_in);
    #1;
    `CHK("rst_port", 8'hff, port_reset_value_out)
    @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_in);
      cfg1_fuse_in <= {~i[0], i[0], i[1], i[2], i[1], i[2:0]};
      shared_reset_port_pin_in <= i[1];
      repeat (2) @(posedge clock_in);
      #1;
      `CHK("osc", i inside {[4:6]} ? 3'h7 : i[2:0], osc_sel_out)
      `CHK("osc_res", i inside {[4:6]}, osc_reserved_out)
      `CHK("rst_pin", !i[0] && !i[1], ext_reset_out)
      `CHK("port_pin", i[0] && i[1], port_pin_in_out)
      `CHK("port_level", i[1], port_reset_level_out)
      `CHK("brownout", i[2], brownout_sel_out)
      `CHK("watchdog", ~i[0], watchdog_enable_out)
      `CHK("clock_rate", i[1], clock_rate_out)
    end
    $display("config test done");
    rd(`CFS_CFG1_ADDR, 8'h7f, 1'b1);
    rd(`CFS_CFG2_ADDR, 8'h96, 1'b1);
    rd(16'h0, 8'h0, 1'b0);
    $display("read test done");
    sec(2'h3);
    sec(2'h2);
    sec(2'h0);
    @(posedge clock_in);
    lock_fuse_in <= 2'h3;
    prog_lock_data_in <= 2'h1;
    repeat (2) @(posedge clock_in);
    prog_lock_wr_in <= 1'b1;
    #1;
    `CHK("lock_sb2_only", 1'b0, lock_wr_en_out)
    @(posedge clock_in);
    prog_lock_wr_in <= 1'b0;
    #1;
    `CHK("lock_refused", 1'b1, prog_refused_out)
    $display("security test done");
    test_done();
  end
  initial begin
    #4000;
    fail_count++;
    test_done();
  end
endmodule
